// ---- led_pattern_pkg.sv ----
// Shared constants, types and lookups for the LED pattern generator
package led_pattern_pkg;

    // Time base: one phase is 256 steps, each step lasts its duration in ms base ticks
    localparam int CLK_NS = 50;
    localparam int MS_NS = 1000000;
    localparam int STEPS = 256;
    localparam int TICK_CYC = MS_NS / STEPS / CLK_NS;

    // Register offsets
    localparam logic [7:0] ADDR_ENABLE = 8'h01;
    localparam logic [7:0] ADDR_LEVEL1 = 8'h11;
    localparam logic [7:0] ADDR_LEVEL2 = 8'h12;
    localparam logic [7:0] ADDR_LEVEL3 = 8'h13;
    localparam logic [7:0] ADDR_LEVEL4 = 8'h14;
    localparam logic [7:0] ADDR_SHAPE = 8'h15;
    localparam logic [7:0] ADDR_RISE = 8'h16;
    localparam logic [7:0] ADDR_FALL = 8'h17;
    localparam logic [7:0] ADDR_ON = 8'h18;
    localparam logic [7:0] ADDR_OFF = 8'h19;
    localparam logic [7:0] ADDR_PULSE = 8'h1a;
    localparam logic [7:0] ADDR_MASK12 = 8'h1b;
    localparam logic [7:0] ADDR_MASK34 = 8'h1c;
    localparam logic [7:0] ADDR_STATUS = 8'h1d;
    localparam logic [7:0] ADDR_AUDIO = 8'h43;

    // Reset values and field limits
    localparam logic [3:0] SPEED_RST = 4'h8;
    localparam logic [2:0] SKIP_MAX = 3'h4;
    localparam logic [13:0] ON_UNIT_MS = 14'd50;
    localparam logic [7:0] ON_MAX = 8'h54;
    localparam logic [13:0] OFF_UNIT_MS = 14'd80;
    localparam logic [7:0] OFF_MAX = 8'h69;
    localparam logic [13:0] PAUSE_UNIT_MS = 14'd36;
    localparam logic [7:0] LAST_STEP = 8'hff;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_RISE = 6'h02,
        ST_ON = 6'h04,
        ST_FALL = 6'h08,
        ST_PAUSE = 6'h10,
        ST_OFF = 6'h20
    } phase_type;

    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    // Timing shared by all four channels
    typedef struct packed {
        logic [3:0] rise_duration;
        logic [3:0] fall_duration;
        logic [7:0] on_code;
        logic [7:0] off_code;
        logic [3:0] pause_duration;
        logic [2:0] pulses;
        logic linear;
    } timing_type;

    // Dim speed code to milliseconds
    function automatic logic [13:0] speed_ms(input logic [3:0] code);
        case (code)
            4'h0: speed_ms = 14'd0;
            4'h1: speed_ms = 14'd120;
            4'h2: speed_ms = 14'd250;
            4'h3: speed_ms = 14'd380;
            4'h4: speed_ms = 14'd510;
            4'h5: speed_ms = 14'd770;
            4'h6: speed_ms = 14'd1000;
            4'h7: speed_ms = 14'd1600;
            4'h8: speed_ms = 14'd2100;
            4'h9: speed_ms = 14'd2600;
            4'ha: speed_ms = 14'd3100;
            4'hb: speed_ms = 14'd4200;
            4'hc: speed_ms = 14'd5200;
            4'hd: speed_ms = 14'd6200;
            4'he: speed_ms = 14'd7300;
            default: speed_ms = 14'd8300;
        endcase
    endfunction : speed_ms

endpackage : led_pattern_pkg

// ---- led_pattern_generator.sv ----
// Four-channel LED pattern generator with frame masking and audio hand-over
// Summary of operation
// - Bits 3..0 at 0x43 pick pattern (0) or audio (1) per channel.
// - Each channel ramps from off to its target over the rise time.
// - Ramps are logarithmic by default; a configuration bit makes them linear.
// - After the on phase each channel dims to off over the fall time.
// - Between ramps each channel holds its target for the on time.
// - After the fall ramp channels stay off, then the cycle restarts.
// - All timing settings are shared; target level, skip setting and audio select are per channel.
// - All channels run the pattern in lockstep from one start instant.
// - Multiple-pulse mode puts a pause between pulses of one cycle.
// - Multiple-pulse mode repeats rise, on, fall per pulse count before off.
// - The pattern forms a frame repeated endlessly while enabled.
// - Each channel has its own skip setting of zero to four frames.
// - Setting N plays one frame, then suppresses the next N frames.
// - Masking works with single and multiple pulses, no timing of its own.
// - A 4-bit dim speed code selects ramp time; resets to 0x08.
// - Shape bit: 0 logarithmic, 1 linear; resets to 0.
`timescale 1ns/100ps
module led_pattern_generator (
    input wire logic clk,
    input wire logic rst_b,
    input wire led_pattern_pkg::reg_req_type reg_req,
    output logic [7:0] reg_rdata,
    input wire logic [3:0][7:0] audio_level,
    output logic [7:0] led_channel_1,
    output logic [7:0] led_channel_2,
    output logic [7:0] led_channel_3,
    output logic [7:0] led_channel_4
);

    // Brightness curve; the log form is a piecewise exponential, cheap in gates
    function automatic logic [7:0] curve(input logic [7:0] s, input logic lin);
        logic [12:0] e;
        e = 13'({1'b1, s[4:0]}) << s[7:5];
        curve = lin ? s : 8'((e >> 5) - 13'd1);
    endfunction : curve

    // Hold time from a code, clamped to the legal range
    function automatic logic [13:0] hold_ms(input logic [7:0] code, input logic [7:0] lim,
                                            input logic [13:0] unit);
        logic [7:0] c;
        c = (code == 8'h00) ? 8'h01 : ((code > lim) ? lim : code);
        hold_ms = 14'(c * unit);
    endfunction : hold_ms

    // Register storage
    logic enable_ff;
    logic [3:0][7:0] level_ff;
    led_pattern_pkg::timing_type tim_ff;
    logic [3:0][2:0] skip_ff;
    logic [7:0] audio_sel_ff;
    logic [7:0] rdata_ff;

    // Sequencer state
    led_pattern_pkg::phase_type phase_ff;
    led_pattern_pkg::phase_type nxt_phase;
    logic [6:0] tick_cnt_ff;
    logic [13:0] sub_ff;
    logic [7:0] step_ff;
    logic [2:0] pulse_ff;
    logic [3:0][2:0] mask_cnt_ff;
    logic [3:0][7:0] led_ff;

    // Per-channel hand-over to the audio path, gathered for the channel loop
    wire ch1_sound_sync_sel = audio_sel_ff[0];
    wire ch2_sound_sync_sel = audio_sel_ff[1];
    wire ch3_sound_sync_sel = audio_sel_ff[2];
    wire ch4_sound_sync_sel = audio_sel_ff[3];
    wire [3:0] sound_sync_sel = {ch4_sound_sync_sel, ch3_sound_sync_sel, ch2_sound_sync_sel,
                                 ch1_sound_sync_sel};

    // Register write; no side effects besides storage
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            enable_ff <= 1'b0;
            level_ff <= '0;
            tim_ff <= '0;
            tim_ff.rise_duration <= led_pattern_pkg::SPEED_RST;
            tim_ff.fall_duration <= led_pattern_pkg::SPEED_RST;
            tim_ff.linear <= 1'b0;
            skip_ff <= '0;
            audio_sel_ff <= 8'h00;
        end else if (reg_req.we) begin
            case (reg_req.addr)
                led_pattern_pkg::ADDR_ENABLE: enable_ff <= reg_req.wdata[0];
                led_pattern_pkg::ADDR_LEVEL1: level_ff[0] <= reg_req.wdata;
                led_pattern_pkg::ADDR_LEVEL2: level_ff[1] <= reg_req.wdata;
                led_pattern_pkg::ADDR_LEVEL3: level_ff[2] <= reg_req.wdata;
                led_pattern_pkg::ADDR_LEVEL4: level_ff[3] <= reg_req.wdata;
                led_pattern_pkg::ADDR_SHAPE: tim_ff.linear <= reg_req.wdata[1];
                led_pattern_pkg::ADDR_RISE: tim_ff.rise_duration <= reg_req.wdata[7:4];
                led_pattern_pkg::ADDR_FALL: tim_ff.fall_duration <= reg_req.wdata[3:0];
                led_pattern_pkg::ADDR_ON: tim_ff.on_code <= reg_req.wdata;
                led_pattern_pkg::ADDR_OFF: tim_ff.off_code <= reg_req.wdata;
                led_pattern_pkg::ADDR_PULSE: begin
                    tim_ff.pause_duration <= reg_req.wdata[3:0];
                    tim_ff.pulses <= reg_req.wdata[6:4];
                end
                led_pattern_pkg::ADDR_MASK12: skip_ff[1:0] <= {reg_req.wdata[6:4],
                                                                reg_req.wdata[2:0]};
                led_pattern_pkg::ADDR_MASK34: skip_ff[3:2] <= {reg_req.wdata[6:4],
                                                                reg_req.wdata[2:0]};
                led_pattern_pkg::ADDR_AUDIO: audio_sel_ff <= {4'h0, reg_req.wdata[3:0]};
                default: ;
            endcase
        end
    end

    // Read decode; upper bits of the select register read as zero
    wire [7:0] rd_val =
        (reg_req.addr == led_pattern_pkg::ADDR_ENABLE) ? {7'h00, enable_ff} :
        (reg_req.addr == led_pattern_pkg::ADDR_LEVEL1) ? level_ff[0] :
        (reg_req.addr == led_pattern_pkg::ADDR_LEVEL2) ? level_ff[1] :
        (reg_req.addr == led_pattern_pkg::ADDR_LEVEL3) ? level_ff[2] :
        (reg_req.addr == led_pattern_pkg::ADDR_LEVEL4) ? level_ff[3] :
        (reg_req.addr == led_pattern_pkg::ADDR_SHAPE) ? {6'h00, tim_ff.linear, 1'b0} :
        (reg_req.addr == led_pattern_pkg::ADDR_RISE) ? {tim_ff.rise_duration, 4'h0} :
        (reg_req.addr == led_pattern_pkg::ADDR_FALL) ? {4'h0, tim_ff.fall_duration} :
        (reg_req.addr == led_pattern_pkg::ADDR_ON) ? tim_ff.on_code :
        (reg_req.addr == led_pattern_pkg::ADDR_OFF) ? tim_ff.off_code :
        (reg_req.addr == led_pattern_pkg::ADDR_PULSE) ?
            {1'b0, tim_ff.pulses, tim_ff.pause_duration} :
        (reg_req.addr == led_pattern_pkg::ADDR_MASK12) ?
            {1'b0, skip_ff[1], 1'b0, skip_ff[0]} :
        (reg_req.addr == led_pattern_pkg::ADDR_MASK34) ?
            {1'b0, skip_ff[3], 1'b0, skip_ff[2]} :
        (reg_req.addr == led_pattern_pkg::ADDR_STATUS) ? {2'b00, phase_ff} :
        (reg_req.addr == led_pattern_pkg::ADDR_AUDIO) ? audio_sel_ff : 8'h00;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= rd_val;
        end
    end

    assign reg_rdata = rdata_ff;

    // Base tick: one 256th of a millisecond
    wire tick = (tick_cnt_ff == 7'(led_pattern_pkg::TICK_CYC - 1));

    always_ff @(posedge clk) begin
        if (!rst_b || tick) begin
            tick_cnt_ff <= 7'h00;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 7'h01;
        end
    end

    // Duration of the current phase in ms, one set of timing for all channels
    wire [13:0] dur_ms =
        (phase_ff == led_pattern_pkg::ST_RISE) ? led_pattern_pkg::speed_ms(tim_ff.rise_duration) :
        (phase_ff == led_pattern_pkg::ST_FALL) ? led_pattern_pkg::speed_ms(tim_ff.fall_duration) :
        (phase_ff == led_pattern_pkg::ST_ON) ?
            hold_ms(tim_ff.on_code, led_pattern_pkg::ON_MAX, led_pattern_pkg::ON_UNIT_MS) :
        (phase_ff == led_pattern_pkg::ST_OFF) ?
            hold_ms(tim_ff.off_code, led_pattern_pkg::OFF_MAX, led_pattern_pkg::OFF_UNIT_MS) :
        (phase_ff == led_pattern_pkg::ST_PAUSE) ?
            14'(tim_ff.pause_duration * led_pattern_pkg::PAUSE_UNIT_MS) : 14'd0;

    // A step ends after dur_ms ticks; 256 steps make the phase
    wire sub_last = (sub_ff >= dur_ms - 14'd1);
    wire step_end = tick && sub_last;
    wire phase_end = (dur_ms == 14'd0) ||
                     (step_end && step_ff == led_pattern_pkg::LAST_STEP);
    wire more_pulses = (pulse_ff < tim_ff.pulses);
    wire frame_end = (phase_ff == led_pattern_pkg::ST_OFF) && phase_end;

    // Phase order: rise, on, fall, then pause and repeat or off
    always_comb begin
        nxt_phase = phase_ff;
        if (!enable_ff) begin
            nxt_phase = led_pattern_pkg::ST_IDLE;
        end else begin
            case (phase_ff)
                led_pattern_pkg::ST_IDLE: nxt_phase = led_pattern_pkg::ST_RISE;
                led_pattern_pkg::ST_RISE:
                    if (phase_end) nxt_phase = led_pattern_pkg::ST_ON;
                led_pattern_pkg::ST_ON:
                    if (phase_end) nxt_phase = led_pattern_pkg::ST_FALL;
                led_pattern_pkg::ST_FALL:
                    if (phase_end) nxt_phase = more_pulses ? led_pattern_pkg::ST_PAUSE
                                                           : led_pattern_pkg::ST_OFF;
                led_pattern_pkg::ST_PAUSE:
                    if (phase_end) nxt_phase = led_pattern_pkg::ST_RISE;
                led_pattern_pkg::ST_OFF:
                    if (phase_end) nxt_phase = led_pattern_pkg::ST_RISE;
                default: nxt_phase = led_pattern_pkg::ST_IDLE;
            endcase
        end
    end

    wire phase_chg = (nxt_phase != phase_ff);
    wire [13:0] nxt_sub = (phase_chg || step_end) ? 14'd0 : (tick ? sub_ff + 14'd1 : sub_ff);
    wire [7:0] nxt_step = phase_chg ? 8'h00 : (step_end ? step_ff + 8'h01 : step_ff);
    // Pulse count must survive on and fall, or the last pulse never reaches off
    wire [2:0] nxt_pulse = (phase_ff == led_pattern_pkg::ST_PAUSE && phase_chg) ?
                           pulse_ff + 3'h1 :
                           ((phase_ff == led_pattern_pkg::ST_IDLE ||
                             phase_ff == led_pattern_pkg::ST_OFF) ? 3'h0 : pulse_ff);

    // Sequencer registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            phase_ff <= led_pattern_pkg::ST_IDLE;
            sub_ff <= 14'd0;
            step_ff <= 8'h00;
            pulse_ff <= 3'h0;
        end else begin
            phase_ff <= nxt_phase;
            sub_ff <= nxt_sub;
            step_ff <= nxt_step;
            pulse_ff <= nxt_pulse;
        end
    end

    // Shared brightness fraction; fall runs the curve backwards
    wire [7:0] pat =
        (phase_ff == led_pattern_pkg::ST_RISE) ? curve(step_ff, tim_ff.linear) :
        (phase_ff == led_pattern_pkg::ST_ON) ? led_pattern_pkg::LAST_STEP :
        (phase_ff == led_pattern_pkg::ST_FALL) ? curve(~step_ff, tim_ff.linear) : 8'h00;
    wire [8:0] pat_p1 = {1'b0, pat} + 9'h001;

    // Per-channel mask counters and output levels
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_ch
            wire [2:0] skip = (skip_ff[ch] > led_pattern_pkg::SKIP_MAX) ?
                              led_pattern_pkg::SKIP_MAX : skip_ff[ch];
            wire play = (mask_cnt_ff[ch] == 3'h0);
            wire [16:0] prod = level_ff[ch] * pat_p1;
            wire [7:0] scaled = prod[15:8];
            // Counter wraps after N skipped frames, so play one and drop N
            wire [2:0] nxt_cnt = (phase_ff == led_pattern_pkg::ST_IDLE) ? 3'h0 :
                                 (!frame_end) ? mask_cnt_ff[ch] :
                                 (mask_cnt_ff[ch] >= skip) ? 3'h0 :
                                 mask_cnt_ff[ch] + 3'h1;
            // Audio select overrides everything; pattern timing keeps running
            wire [7:0] nxt_led = sound_sync_sel[ch] ? audio_level[ch] :
                                 (play ? scaled : 8'h00);
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    mask_cnt_ff[ch] <= 3'h0;
                    led_ff[ch] <= 8'h00;
                end else begin
                    mask_cnt_ff[ch] <= nxt_cnt;
                    led_ff[ch] <= nxt_led;
                end
            end
        end
    endgenerate

    assign led_channel_1 = led_ff[0];
    assign led_channel_2 = led_ff[1];
    assign led_channel_3 = led_ff[2];
    assign led_channel_4 = led_ff[3];

    // Checks on the sequencer and channel outputs
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    idle_when_off_a: assert property (!enable_ff |=> phase_ff == led_pattern_pkg::ST_IDLE)
        else $error("sequencer not idle while disabled");
    restart_after_off_a: assert property (frame_end && enable_ff
        |=> phase_ff == led_pattern_pkg::ST_RISE && step_ff == 8'h00)
        else $error("cycle did not restart after off");
    on_after_rise_a: assert property (phase_ff == led_pattern_pkg::ST_RISE && phase_end
        && enable_ff |=> phase_ff == led_pattern_pkg::ST_ON)
        else $error("on phase did not follow rise");
    fall_after_on_a: assert property (phase_ff == led_pattern_pkg::ST_ON && phase_end
        && enable_ff |=> phase_ff == led_pattern_pkg::ST_FALL)
        else $error("fall did not follow on");
    pause_between_a: assert property (phase_ff == led_pattern_pkg::ST_FALL && phase_end
        && enable_ff && more_pulses |=> phase_ff == led_pattern_pkg::ST_PAUSE)
        else $error("pause missing between pulses");
    off_after_last_a: assert property (phase_ff == led_pattern_pkg::ST_FALL && phase_end
        && enable_ff && !more_pulses |=> phase_ff == led_pattern_pkg::ST_OFF)
        else $error("off phase missing after last pulse");
    audio_follow_a: assert property (sound_sync_sel[0] |=> led_ff[0] == $past(audio_level[0]))
        else $error("audio channel not following audio level");
    masked_zero_a: assert property (mask_cnt_ff[1] != 3'h0 && !sound_sync_sel[1]
        |=> led_ff[1] == 8'h00)
        else $error("masked channel not at zero");
    on_full_level_a: assert property (phase_ff == led_pattern_pkg::ST_ON
        && mask_cnt_ff[2] == 3'h0 && !sound_sync_sel[2] |=> led_ff[2] == $past(level_ff[2]))
        else $error("on phase not at target level");
    linear_ramp_a: assert property (phase_ff == led_pattern_pkg::ST_RISE && tim_ff.linear
        && level_ff[0] == 8'hff && mask_cnt_ff[0] == 3'h0 && !sound_sync_sel[0]
        |=> led_ff[0] == $past(step_ff))
        else $error("linear ramp level wrong");
    mask_bound_a: assert property (mask_cnt_ff[3] <= led_pattern_pkg::SKIP_MAX)
        else $error("mask counter out of range");

    frame_done_c: cover property (frame_end);
    pause_seen_c: cover property (phase_ff == led_pattern_pkg::ST_PAUSE);
    masked_frame_c: cover property (frame_end && mask_cnt_ff[3] == 3'h3);

endmodule : led_pattern_generator

// ---- led_load_model.sv ----
// Behavioural load of four LEDs hanging on the current source outputs
`timescale 1ns/100ps
module led_load_model (
    input wire logic [7:0] led_channel_1,
    input wire logic [7:0] led_channel_2,
    input wire logic [7:0] led_channel_3,
    input wire logic [7:0] led_channel_4,
    output logic [3:0] lit
);
    // An LED glows whenever its source gives any current; a load cannot refuse or stall
    assign lit[0] = (led_channel_1 != 8'h00);
    assign lit[1] = (led_channel_2 != 8'h00);
    assign lit[2] = (led_channel_3 != 8'h00);
    assign lit[3] = (led_channel_4 != 8'h00);
endmodule : led_load_model

// ---- led_pattern_generator_tb_top.sv ----
// Self-checking testbench for the LED pattern generator
`timescale 1ns/100ps
module led_pattern_generator_tb_top;
    logic clk;
    logic rst_b;
    led_pattern_pkg::reg_req_type reg_req;
    logic [7:0] reg_rdata;
    logic [3:0][7:0] audio_level;
    logic [7:0] led_channel_1;
    logic [7:0] led_channel_2;
    logic [7:0] led_channel_3;
    logic [7:0] led_channel_4;
    logic [3:0] lit;
    logic [7:0] rd;
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    // One ramp step at dim code 1 is 120 base ticks of 78 cycles; sample mid step 2
    localparam int MID_STEP2 = 23400;

    led_pattern_generator i_led_pattern_generator (
        .clk(clk),
        .rst_b(rst_b),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata),
        .audio_level(audio_level),
        .led_channel_1(led_channel_1),
        .led_channel_2(led_channel_2),
        .led_channel_3(led_channel_3),
        .led_channel_4(led_channel_4)
    );

    led_load_model i_led_load_model (
        .led_channel_1(led_channel_1),
        .led_channel_2(led_channel_2),
        .led_channel_3(led_channel_3),
        .led_channel_4(led_channel_4),
        .lit(lit)
    );

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Two sampled ramps dominate the run; anything far beyond them is a hang
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_errors++;
            $display("mismatch at %0t: run did not finish", $time);
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check_byte

    task automatic check_lit(input logic [3:0] exp);
        num_checks++;
        if (lit !== exp) begin
            n_errors++;
            $display("mismatch at %0t: lit LEDs %b expected %b", $time, lit, exp);
        end
    endtask : check_lit

    // Write strobe stands for exactly one rising edge
    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk);
        reg_req.we = 1'b1;
        reg_req.addr = addr;
        reg_req.wdata = data;
        @(negedge clk);
        reg_req.we = 1'b0;
    endtask : reg_write

    // Read data is registered, so it is taken one cycle after the address
    task automatic check_reg(input logic [7:0] addr, input logic [7:0] exp);
        @(negedge clk);
        reg_req.addr = addr;
        @(negedge clk);
        rd = reg_rdata;
        check_byte(rd, exp, "register read");
    endtask : check_reg

    task automatic check_leds(input logic [7:0] c1, input logic [7:0] c2,
                              input logic [7:0] c3, input logic [7:0] c4);
        check_byte(led_channel_1, c1, "channel 1");
        check_byte(led_channel_2, c2, "channel 2");
        check_byte(led_channel_3, c3, "channel 3");
        check_byte(led_channel_4, c4, "channel 4");
    endtask : check_leds

    // Main sequence
    initial begin
        rst_b = 1'b0;
        reg_req = '0;
        audio_level = {8'h44, 8'h33, 8'h22, 8'h11};
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        check_lit(4'h0);
        check_reg(led_pattern_pkg::ADDR_RISE, 8'h80);
        check_reg(led_pattern_pkg::ADDR_FALL, 8'h08);
        check_reg(led_pattern_pkg::ADDR_SHAPE, 8'h00);
        check_reg(led_pattern_pkg::ADDR_AUDIO, 8'h00);
        check_reg(led_pattern_pkg::ADDR_STATUS, 8'h01);
        reg_write(led_pattern_pkg::ADDR_AUDIO, 8'hff);
        check_reg(led_pattern_pkg::ADDR_AUDIO, 8'h0f);
        reg_write(led_pattern_pkg::ADDR_AUDIO, 8'h00);
        reg_write(8'h50, 8'h5a);
        check_reg(8'h50, 8'h00);
        reg_write(led_pattern_pkg::ADDR_STATUS, 8'hff);
        check_reg(led_pattern_pkg::ADDR_STATUS, 8'h01);
        reg_write(led_pattern_pkg::ADDR_PULSE, 8'h7f);
        check_reg(led_pattern_pkg::ADDR_PULSE, 8'h7f);
        reg_write(led_pattern_pkg::ADDR_MASK12, 8'h44);
        check_reg(led_pattern_pkg::ADDR_MASK12, 8'h44);
        reg_write(led_pattern_pkg::ADDR_MASK12, 8'h00);
        reg_write(led_pattern_pkg::ADDR_LEVEL1, 8'hff);
        reg_write(led_pattern_pkg::ADDR_LEVEL2, 8'h80);
        reg_write(led_pattern_pkg::ADDR_LEVEL3, 8'h40);
        reg_write(led_pattern_pkg::ADDR_LEVEL4, 8'h20);
        // Linear ramp at the shortest non-zero dim speed, sampled mid step 2
        reg_write(led_pattern_pkg::ADDR_SHAPE, 8'h02);
        reg_write(led_pattern_pkg::ADDR_RISE, 8'h10);
        reg_write(led_pattern_pkg::ADDR_ENABLE, 8'h01);
        check_reg(led_pattern_pkg::ADDR_STATUS, 8'h02);
        repeat (MID_STEP2 - 2) @(negedge clk);
        check_leds(8'h02, 8'h01, 8'h00, 8'h00);
        reg_write(led_pattern_pkg::ADDR_ENABLE, 8'h00);
        repeat (2) @(negedge clk);
        check_lit(4'h0);
        // Logarithmic ramp stays dark where the linear one already glows
        reg_write(led_pattern_pkg::ADDR_SHAPE, 8'h00);
        reg_write(led_pattern_pkg::ADDR_ENABLE, 8'h01);
        repeat (MID_STEP2) @(negedge clk);
        check_leds(8'h00, 8'h00, 8'h00, 8'h00);
        check_reg(led_pattern_pkg::ADDR_STATUS, 8'h02);
        reg_write(led_pattern_pkg::ADDR_ENABLE, 8'h00);
        // Immediate rise lands in the on phase at the full targets
        reg_write(led_pattern_pkg::ADDR_RISE, 8'h00);
        reg_write(led_pattern_pkg::ADDR_ENABLE, 8'h01);
        repeat (4) @(negedge clk);
        check_leds(8'hff, 8'h80, 8'h40, 8'h20);
        check_lit(4'hf);
        check_reg(led_pattern_pkg::ADDR_STATUS, 8'h04);
        // Hand channels 2 and 4 to the audio path, then take them back
        reg_write(led_pattern_pkg::ADDR_AUDIO, 8'h0a);
        repeat (3) @(negedge clk);
        check_leds(8'hff, 8'h22, 8'h40, 8'h44);
        reg_write(led_pattern_pkg::ADDR_AUDIO, 8'h00);
        repeat (3) @(negedge clk);
        check_leds(8'hff, 8'h80, 8'h40, 8'h20);
        reg_write(led_pattern_pkg::ADDR_ENABLE, 8'h00);
        repeat (3) @(negedge clk);
        check_lit(4'h0);
        check_reg(led_pattern_pkg::ADDR_STATUS, 8'h01);
        test_done();
    end
endmodule : led_pattern_generator_tb_top
